/* File: rtl/ccedet_defines.svh */
// Register offsets, field positions and reset values of the comparator control block
`ifndef CCEDET_DEFINES_SVH
`define CCEDET_DEFINES_SVH

`define CCEDET_ADDR_W 12
`define CCEDET_OFF_CTRL 12'h000
`define CCEDET_OFF_IRQ_STATUS 12'h004
`define CCEDET_OFF_IRQ_MASK 12'h008

`define CCEDET_BIT_ENABLE 7
`define CCEDET_BIT_REF_SEL 6
`define CCEDET_BIT_FLAG 5
`define CCEDET_BIT_IRQ_EN 4
`define CCEDET_BIT_OUT_STATUS 3
`define CCEDET_BIT_PIN_EN 2
`define CCEDET_BIT_MODE_HI 1
`define CCEDET_BIT_MODE_LO 0
`define CCEDET_BIT_EVENT 0

`define CCEDET_CTRL_RESET 8'h00
`define CCEDET_MASK_RESET 8'h01
`define CCEDET_STATUS_RESET 8'h00

`endif

/* File: rtl/ccedet_pkg.sv */
// Types shared by the comparator control block
package ccedet_pkg;

    typedef logic [7:0] ccedet_byte_t;

    typedef enum logic [1:0] {
        CCEDET_ST_IDLE = 2'b00,
        CCEDET_ST_ANSWER = 2'b01
    } ccedet_apb_state_e;

    typedef enum logic [1:0] {
        CCEDET_MODE_FALL_A = 2'b00,
        CCEDET_MODE_RISE = 2'b01,
        CCEDET_MODE_FALL_B = 2'b10,
        CCEDET_MODE_EITHER = 2'b11
    } ccedet_edge_mode_e;

    typedef struct packed {
        logic comparator_block_enable;
        logic positive_input_reference_select;
        logic event_interrupt_enable;
        logic output_pin_drive_enable;
        ccedet_edge_mode_e event_edge_select;
    } ccedet_ctrl_s;

endpackage

/* File: rtl/ccedet_sync_if.sv */
// Carrier between the control logic and the comparator output synchroniser
`timescale 1ns/1ps
interface ccedet_sync_if;
    logic raw;
    logic clear;
    logic level;

    modport ctrl (output raw, output clear, input level);
    modport sync (input raw, input clear, output level);
endinterface

/* File: rtl/ccedet_sync.sv */
// Three-stage synchroniser with agreement filter for the comparator result
`timescale 1ns/1ps
module ccedet_sync (
    input wire logic sys_clk,
    input wire logic rst_n,
    ccedet_sync_if.sync link
);

    logic ff1;
    logic ff2;
    logic ff3;
    logic level;
    logic next_level;

    // A new level counts only once the second and third stage agree
    always_comb begin
        next_level = level;
        if (link.clear) begin
            next_level = 1'b0;
        end else if (ff2 == ff3) begin
            next_level = ff3;
        end
    end

    // Only ff2 reads ff1, so a metastable first stage never reaches logic
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ff1 <= 1'b0;
            ff2 <= 1'b0;
            ff3 <= 1'b0;
            level <= 1'b0;
        end else begin
            ff1 <= link.raw;
            ff2 <= ff1;
            ff3 <= ff2;
            level <= next_level;
        end
    end

    assign link.level = level;

endmodule

/* File: rtl/ccedet_top.sv */
// Comparator control, edge detection and APB register slave
//
// Implementation choices: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "ccedet_defines.svh"
module ccedet_top #(
    parameter int LEVEL_W = 8
) (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [LEVEL_W-1:0] positive_input_pin,
    input wire logic [LEVEL_W-1:0] negative_input_pin,
    input wire logic [LEVEL_W-1:0] bandgap_reference,
    input wire logic light_stop,
    input wire logic deep_stop,
    output logic comparator_output_pin,
    output logic comparator_output_pin_oe,
    output logic comparator_power_enable,
    output logic analog_reference_select,
    output logic irq,
    output logic wakeup_request
);

    ////////////////////////////////////////////////////////////////////////
    // Reset release

    logic rst_ff1;
    logic rst_n;

    // Assertion is immediate, release waits two edges to avoid removal hazards
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            rst_ff1 <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_ff1 <= 1'b1;
            rst_n <= rst_ff1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Address decode

    // Shared by the read path and the write path
    function automatic logic addr_hit(input logic [11:0] addr, input logic [11:0] off);
        addr_hit = (addr == off);
    endfunction

    function automatic logic addr_mapped(input logic [11:0] addr);
        addr_mapped = addr_hit(addr, `CCEDET_OFF_CTRL) || addr_hit(addr, `CCEDET_OFF_IRQ_STATUS) ||
                      addr_hit(addr, `CCEDET_OFF_IRQ_MASK);
    endfunction

    // Unpacks a control byte field by field; the byte is wider than the stored struct
    function automatic ccedet_pkg::ccedet_ctrl_s ctrl_from_byte(input ccedet_pkg::ccedet_byte_t b);
        ccedet_pkg::ccedet_ctrl_s c;
        c.comparator_block_enable = b[`CCEDET_BIT_ENABLE];
        c.positive_input_reference_select = b[`CCEDET_BIT_REF_SEL];
        c.event_interrupt_enable = b[`CCEDET_BIT_IRQ_EN];
        c.output_pin_drive_enable = b[`CCEDET_BIT_PIN_EN];
        c.event_edge_select = ccedet_pkg::ccedet_edge_mode_e'(b[`CCEDET_BIT_MODE_HI:`CCEDET_BIT_MODE_LO]);
        return c;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // State

    ccedet_pkg::ccedet_ctrl_s ctrl;
    ccedet_pkg::ccedet_ctrl_s next_ctrl;
    logic compare_event_flag;
    logic next_compare_event_flag;
    ccedet_pkg::ccedet_byte_t irq_mask;
    ccedet_pkg::ccedet_byte_t next_irq_mask;
    logic prev_level;
    logic next_prev_level;
    ccedet_pkg::ccedet_apb_state_e apb_state;
    ccedet_pkg::ccedet_apb_state_e next_apb_state;
    logic [31:0] next_prdata;
    logic next_pready;
    logic next_pslverr;
    logic next_comparator_output_pin;
    logic next_comparator_output_pin_oe;
    logic next_comparator_power_enable;
    logic next_analog_reference_select;
    logic next_irq;
    logic next_wakeup_request;

    ////////////////////////////////////////////////////////////////////////
    // Comparator result and synchroniser

    ccedet_sync_if sync_link ();

    logic [LEVEL_W-1:0] selected_positive;
    logic compare_raw;
    logic live_level;
    logic output_status;

    // Positive input mux, then the compare itself; gated off when disabled
    always_comb begin
        selected_positive = ctrl.positive_input_reference_select ? bandgap_reference
                                                                 : positive_input_pin;
        compare_raw = ctrl.comparator_block_enable &&
                      (selected_positive > negative_input_pin);
    end

    assign sync_link.raw = compare_raw;
    assign sync_link.clear = deep_stop || !ctrl.comparator_block_enable;
    assign live_level = sync_link.level;

    ccedet_sync u_sync (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .link(sync_link)
    );

    // Status bit forced low whenever the block is off
    assign output_status = ctrl.comparator_block_enable && live_level;

    ////////////////////////////////////////////////////////////////////////
    // Edge detection

    logic rise_edge;
    logic fall_edge;
    logic compare_event;

    // Edges are only meaningful while enabled; the level is cleared when off
    always_comb begin
        rise_edge = live_level && !prev_level;
        fall_edge = !live_level && prev_level;
        unique case (ctrl.event_edge_select)
            ccedet_pkg::CCEDET_MODE_FALL_A: compare_event = fall_edge;
            ccedet_pkg::CCEDET_MODE_RISE: compare_event = rise_edge;
            ccedet_pkg::CCEDET_MODE_FALL_B: compare_event = fall_edge;
            ccedet_pkg::CCEDET_MODE_EITHER: compare_event = rise_edge || fall_edge;
        endcase
        compare_event = compare_event && ctrl.comparator_block_enable;
    end

    ////////////////////////////////////////////////////////////////////////
    // APB slave

    logic access;
    logic commit;
    logic wr_commit;
    logic hit_ctrl;
    logic hit_status;
    logic hit_mask;
    logic clear_request;
    ccedet_pkg::ccedet_byte_t ctrl_read;
    ccedet_pkg::ccedet_byte_t status_read;
    ccedet_pkg::ccedet_byte_t read_byte;

    // Read images of the three registers; unused bits read as zero
    always_comb begin
        ctrl_read = `CCEDET_CTRL_RESET;
        ctrl_read[`CCEDET_BIT_ENABLE] = ctrl.comparator_block_enable;
        ctrl_read[`CCEDET_BIT_REF_SEL] = ctrl.positive_input_reference_select;
        ctrl_read[`CCEDET_BIT_FLAG] = compare_event_flag;
        ctrl_read[`CCEDET_BIT_IRQ_EN] = ctrl.event_interrupt_enable;
        ctrl_read[`CCEDET_BIT_OUT_STATUS] = output_status;
        ctrl_read[`CCEDET_BIT_PIN_EN] = ctrl.output_pin_drive_enable;
        ctrl_read[`CCEDET_BIT_MODE_HI:`CCEDET_BIT_MODE_LO] = ctrl.event_edge_select;
        status_read = `CCEDET_STATUS_RESET;
        status_read[`CCEDET_BIT_EVENT] = compare_event_flag;
    end

    // Decode of the presented address and the completing access phase
    always_comb begin
        access = psel && penable;
        hit_ctrl = addr_hit(paddr, `CCEDET_OFF_CTRL);
        hit_status = addr_hit(paddr, `CCEDET_OFF_IRQ_STATUS);
        hit_mask = addr_hit(paddr, `CCEDET_OFF_IRQ_MASK);
        commit = access && (apb_state == ccedet_pkg::CCEDET_ST_ANSWER);
        wr_commit = commit && pwrite && addr_mapped(paddr) && pstrb[0];
        read_byte = 8'h00;
        if (hit_ctrl) begin
            read_byte = ctrl_read;
        end else if (hit_status) begin
            read_byte = status_read;
        end else if (hit_mask) begin
            read_byte = irq_mask;
        end
    end

    // One wait state: the answer is registered in the first access cycle
    always_comb begin
        next_apb_state = apb_state;
        next_pready = 1'b0;
        next_pslverr = 1'b0;
        next_prdata = 32'h0000_0000;
        unique case (apb_state)
            ccedet_pkg::CCEDET_ST_IDLE: begin
                if (access) begin
                    next_apb_state = ccedet_pkg::CCEDET_ST_ANSWER;
                    next_pready = 1'b1;
                    next_pslverr = !addr_mapped(paddr);
                    if (!pwrite) begin
                        next_prdata = {24'h00_0000, read_byte};
                    end
                end
            end
            ccedet_pkg::CCEDET_ST_ANSWER: begin
                next_apb_state = ccedet_pkg::CCEDET_ST_IDLE;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Register and event logic

    // Either register can clear the flag; only a one in that bit does
    always_comb begin
        clear_request = wr_commit && ((hit_ctrl && pwdata[`CCEDET_BIT_FLAG]) ||
                                      (hit_status && pwdata[`CCEDET_BIT_EVENT]));
    end

    // A fresh event in the clearing cycle wins, so a clear never drops an event; deep stop drops it
    always_comb begin
        next_ctrl = ctrl;
        next_irq_mask = irq_mask;
        next_prev_level = live_level;
        next_compare_event_flag = compare_event || (compare_event_flag && !clear_request);
        if (wr_commit && hit_ctrl) begin
            next_ctrl.comparator_block_enable = pwdata[`CCEDET_BIT_ENABLE];
            next_ctrl.positive_input_reference_select = pwdata[`CCEDET_BIT_REF_SEL];
            next_ctrl.event_interrupt_enable = pwdata[`CCEDET_BIT_IRQ_EN];
            next_ctrl.output_pin_drive_enable = pwdata[`CCEDET_BIT_PIN_EN];
            next_ctrl.event_edge_select = ccedet_pkg::ccedet_edge_mode_e'(
                pwdata[`CCEDET_BIT_MODE_HI:`CCEDET_BIT_MODE_LO]);
        end
        if (wr_commit && hit_mask) begin
            next_irq_mask = pwdata[7:0] & 8'h01;
        end
        // Powering down in deep stop loses the control, mask, flag and edge state, as a reset would
        if (deep_stop) begin
            next_ctrl = ctrl_from_byte(`CCEDET_CTRL_RESET);
            next_irq_mask = `CCEDET_MASK_RESET;
            next_compare_event_flag = 1'b0;
            next_prev_level = 1'b0;
        end
    end

    // Outputs follow the next values so each is a flip-flop with no extra lag
    always_comb begin
        next_irq = next_compare_event_flag && next_ctrl.event_interrupt_enable &&
                   next_irq_mask[`CCEDET_BIT_EVENT];
        next_wakeup_request = light_stop && next_compare_event_flag &&
                              next_ctrl.event_interrupt_enable;
        next_comparator_output_pin_oe = next_ctrl.output_pin_drive_enable;
        next_comparator_output_pin = next_ctrl.output_pin_drive_enable &&
                                     next_ctrl.comparator_block_enable && live_level;
        next_comparator_power_enable = next_ctrl.comparator_block_enable;
        next_analog_reference_select = next_ctrl.positive_input_reference_select;
    end

    // Single register stage for all control state and outputs
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl <= ctrl_from_byte(`CCEDET_CTRL_RESET);
            compare_event_flag <= 1'b0;
            irq_mask <= `CCEDET_MASK_RESET;
            prev_level <= 1'b0;
            apb_state <= ccedet_pkg::CCEDET_ST_IDLE;
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
            irq <= 1'b0;
            wakeup_request <= 1'b0;
            comparator_output_pin <= 1'b0;
            comparator_output_pin_oe <= 1'b0;
            comparator_power_enable <= 1'b0;
            analog_reference_select <= 1'b0;
        end else begin
            ctrl <= next_ctrl;
            compare_event_flag <= next_compare_event_flag;
            irq_mask <= next_irq_mask;
            prev_level <= next_prev_level;
            apb_state <= next_apb_state;
            prdata <= next_prdata;
            pready <= next_pready;
            pslverr <= next_pslverr;
            irq <= next_irq;
            wakeup_request <= next_wakeup_request;
            comparator_output_pin <= next_comparator_output_pin;
            comparator_output_pin_oe <= next_comparator_output_pin_oe;
            comparator_power_enable <= next_comparator_power_enable;
            analog_reference_select <= next_analog_reference_select;
        end
    end

endmodule

/* File: dv/ccedet_analog_model.sv */
// Behavioural analog front end and output pin observer for the comparator block
`timescale 1ns/1ps
module ccedet_analog_model #(
    parameter logic [7:0] BANDGAP_CODE = 8'h80
) (
    input wire logic sys_clk,
    input wire logic [7:0] pos_code,
    input wire logic [7:0] neg_code,
    input wire logic pin_level,
    input wire logic pin_oe,
    output logic [7:0] positive_input_pin,
    output logic [7:0] negative_input_pin,
    output logic [7:0] bandgap_reference,
    output logic pin_seen
);
    logic toggle = 1'b0;
    // Levels pass straight through; the block treats them as asynchronous
    assign positive_input_pin = pos_code;
    assign negative_input_pin = neg_code;
    assign bandgap_reference = BANDGAP_CODE;
    // Pin has no pull, so an undriven pin shows a toggling pattern, not a stale level
    always_ff @(posedge sys_clk) begin
        toggle <= !toggle;
    end
    assign pin_seen = pin_oe ? pin_level : toggle;
endmodule

/* File: dv/ccedet_checker.sv */
// Concurrent assertions on the ports of the comparator control block
`timescale 1ns/1ps
module ccedet_checker (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic light_stop,
    input wire logic deep_stop,
    input wire logic comparator_output_pin,
    input wire logic comparator_output_pin_oe,
    input wire logic comparator_power_enable,
    input wire logic analog_reference_select,
    input wire logic irq,
    input wire logic wakeup_request
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    ////////////////////////////////////////////////////////////////////////////
    // Completed write of the control word with the low lane enabled
    sequence wr_ctrl;
        psel && penable && pready && pwrite && paddr == 12'h000 && pstrb[0] && !deep_stop;
    endsequence
    // Setup cycle, one wait cycle, then the answer
    sequence apb_answer;
        !pready ##1 pready;
    endsequence
    chk_enable_follows: assert property (wr_ctrl |-> ##2 comparator_power_enable == $past(pwdata[7], 2))
        else $error("power enable does not follow control write");
    chk_ref_follows: assert property (wr_ctrl |-> ##2 analog_reference_select == $past(pwdata[6], 2))
        else $error("reference select does not follow control write");
    chk_oe_follows: assert property (wr_ctrl |-> ##2 comparator_output_pin_oe == $past(pwdata[2], 2))
        else $error("pin enable does not follow control write");
    chk_apb_wait: assert property ((psel && !penable) |=> apb_answer)
        else $error("answer not after one wait cycle");
    chk_pready_pulse: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    chk_prdata_quiet: assert property (!(pready && !pwrite) |-> prdata == 32'h0)
        else $error("read data outside a read answer");
    chk_error_map: assert property (pready |-> pslverr == !(paddr inside {12'h000, 12'h004, 12'h008}))
        else $error("error response does not match address map");
    chk_status_off: assert property ((pready && !pwrite && paddr == 12'h000 && !prdata[7]) |-> !prdata[3])
        else $error("output status set while disabled");
    chk_pin_gated: assert property (comparator_output_pin |-> comparator_output_pin_oe)
        else $error("pin driven without its enable");
    chk_wake_stop: assert property (wakeup_request |-> $past(light_stop))
        else $error("wake request outside light stop");
    chk_deep_clear: assert property (deep_stop[*2] |-> !comparator_power_enable && !irq && !wakeup_request)
        else $error("deep stop did not clear the block");
endmodule
bind ccedet_top ccedet_checker u_chk (.sys_clk(sys_clk), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .light_stop(light_stop), .deep_stop(deep_stop), .comparator_output_pin(comparator_output_pin),
    .comparator_output_pin_oe(comparator_output_pin_oe), .comparator_power_enable(comparator_power_enable),
    .analog_reference_select(analog_reference_select), .irq(irq), .wakeup_request(wakeup_request));

/* File: dv/ccedet_top_tb.sv */
// Self-checking testbench of the comparator control block
`timescale 1ns/1ps
module ccedet_top_tb;
    localparam logic [7:0] BG = 8'h80;
    logic sys_clk = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rdat;
    logic [3:0] pstrb = 4'hF;
    logic [7:0] pos = 8'h10, neg = 8'h40, posin, negin, bg, p, n;
    logic light_stop = 1'b0, deep_stop = 1'b0, pready, pslverr, rerr;
    logic pin, oe, pwr, refsel, irq, wake, pin_seen;
    int num_errors = 0, num_checks = 0, seed = 32'h84da;
    always #25 sys_clk = ~sys_clk;
    ccedet_top DUT (.sys_clk(sys_clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .positive_input_pin(posin), .negative_input_pin(negin), .bandgap_reference(bg), .light_stop(light_stop),
        .deep_stop(deep_stop), .comparator_output_pin(pin), .comparator_output_pin_oe(oe),
        .comparator_power_enable(pwr), .analog_reference_select(refsel), .irq(irq), .wakeup_request(wake));
    ccedet_analog_model #(.BANDGAP_CODE(BG)) u_model (.sys_clk(sys_clk), .pos_code(pos), .neg_code(neg),
        .pin_level(pin), .pin_oe(oe), .positive_input_pin(posin), .negative_input_pin(negin),
        .bandgap_reference(bg), .pin_seen(pin_seen));
    ////////////////////////////////////////////////////////////////////////////
    // Verdict and end of run
    task automatic report_and_stop();
        $display("checks %0d, mismatches %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge sys_clk);
    endtask
    // One APB transfer; an idle edge first so no signal is driven twice in a step
    task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
        int k;
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge sys_clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge sys_clk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (k >= 20) begin
            num_errors++;
            report_and_stop();
        end
    endtask
    // Set analog levels, then allow the synchroniser and flag to settle
    task automatic level(input logic [7:0] pp, input logic [7:0] nn);
        pos <= pp;
        neg <= nn;
        tick(8);
    endtask
    function automatic logic cmp_exp(logic [7:0] pp, logic [7:0] nn, logic sel);
        return (sel ? BG : pp) > nn;
    endfunction
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        tick(4);
        resetn <= 1'b1;
        tick(3);
        apb(0, 12'h000, 0); check(rdat, 32'h0);
        apb(0, 12'h008, 0); check(rdat, 32'h1);
        apb(0, 12'h00C, 0); check(rerr, 1'b1);
        check(rdat, 32'h0);
        $display("reset test done");
        // Pin input is below, bandgap above the negative level
        for (int s = 0; s < 2; s++) begin
            apb(1, 12'h000, {1'b1, s[0], 6'h00});
            tick(8);
            check(refsel, s[0]);
            apb(0, 12'h000, 0); check(rdat[3], cmp_exp(pos, neg, s[0]));
        end
        apb(1, 12'h000, 8'h40); tick(8);
        apb(0, 12'h000, 0); check(rdat[3], 1'b0);
        check(pwr, 1'b0);
        $display("reference test done");
        for (int m = 0; m < 4; m++) begin
            apb(1, 12'h000, {6'h28, m[1:0]});
            level(8'h60, 8'h40);
            apb(0, 12'h000, 0); check(rdat[5], m == 1 || m == 3);
            apb(1, 12'h000, {6'h28, m[1:0]});
            apb(0, 12'h000, 0); check(rdat[5], 1'b0);
            level(8'h10, 8'h40);
            apb(1, 12'h000, {6'h20, m[1:0]});
            apb(0, 12'h000, 0); check(rdat[5], m != 1);
        end
        $display("edge test done");
        apb(1, 12'h000, 8'hB5);
        level(8'h60, 8'h40);
        check(irq, 1'b1);
        check(pin_seen, 1'b1);
        light_stop <= 1'b1;
        tick(2); check(wake, 1'b1);
        light_stop <= 1'b0;
        apb(1, 12'h008, 0); tick(2); check(irq, 1'b0);
        apb(0, 12'h004, 0); check(rdat, 32'h1);
        apb(1, 12'h008, 1); tick(2); check(irq, 1'b1);
        apb(1, 12'h000, 8'h85); tick(2); check(irq, 1'b0);
        apb(1, 12'h000, 8'h91); apb(1, 12'h004, 1); tick(2); check(irq, 1'b0);
        check(oe, 1'b0);
        $display("interrupt test done");
        level(8'h40, 8'h40);
        apb(0, 12'h000, 0); check(rdat[3], 1'b0);
        for (int i = 0; i < 24; i++) begin
            p = 8'($random(seed));
            n = 8'($random(seed));
            level(p, n);
            apb(0, 12'h000, 0); check(rdat[3], cmp_exp(p, n, 1'b0));
        end
        $display("random compare test done");
        apb(1, 12'h000, 8'hD5); apb(1, 12'h008, 0);
        deep_stop <= 1'b1;
        tick(3);
        deep_stop <= 1'b0;
        apb(0, 12'h000, 0); check(rdat, 32'h0);
        apb(0, 12'h008, 0); check(rdat, 32'h1);
        $display("deep stop test done");
        report_and_stop();
    end
endmodule
